// File: src/mrie_exec.sv
// executor for moves, literal load, no-op and the three returns
`default_nettype none
// Behaviour
// - a register move copies file reg 0..127 to acc, or back to it if d=1.
// - a register move sets the zero flag from the moved value.
// - an acc store writes acc to file reg 0..127 in one cycle, flags kept.
// - a literal load sets acc to its 8-bit value in one cycle, flags kept.
// - unused literal-load bits encode as zero; the decoder ignores them.
// - irq return pops the stack into pc and sets irq enable bit 7.
// - irq return is one word, takes two cycles and keeps all flags.
// - literal return: value to acc, stack top to pc, flags kept.
// - literal return is one word taking two cycles.
// - subroutine return pops stack to pc in two cycles; acc, flags kept.
module mrie_exec (
    // clock and reset
    input  wire logic        I_CLOCK,
    input  wire logic        I_RST,
    // instruction from decoder
    input  wire logic        I_VALID,
    input  wire logic [13:0] I_INSTR,
    // file register read data and stack top
    input  wire logic [7:0]  I_FILE_RDATA,
    input  wire logic [12:0] I_STACK_TOP,
    // file register write
    output logic             O_FILE_WE,
    output logic [6:0]       O_FILE_ADDR,
    output logic [7:0]       O_FILE_WDATA,
    // core state
    output logic [7:0]       O_ACC,
    output logic             O_ZERO,
    output logic [7:0]       O_IRQ_CTRL,
    output logic [12:0]      O_PC,
    output logic             O_STACK_POP,
    output logic             O_FETCH_DISCARD,
    output logic             O_BUSY
);
    // ==========================================================
    // decode
    typedef enum logic [1:0] {
        MRIE_RUN  = 2'b01,
        MRIE_SLOT = 2'b10
    } mrie_state_e;

    mrie_state_e state_q;
    mrie_state_e state_d;

    // both literal forms share one 4-bit prefix test
    function automatic logic lit_form(input logic [13:0] w,
                                      input logic [3:0]  hi);
        return w[mrie_pkg::OPC_MSB:mrie_pkg::LIT_OP_LSB] == hi;
    endfunction

    wire logic take    = I_VALID && (state_q == MRIE_RUN);
    wire logic is_nop  = I_INSTR == mrie_pkg::OP_NOP;
    wire logic is_ret  = I_INSTR == mrie_pkg::OP_RETURN;
    wire logic is_rirq = I_INSTR == mrie_pkg::OP_RETIRQ;
    wire logic is_move = I_INSTR[mrie_pkg::OPC_MSB:mrie_pkg::MOVE_LSB]
                       == mrie_pkg::OP_MOVE_FILE_HI;
    wire logic is_mvwf = I_INSTR[mrie_pkg::OPC_MSB:mrie_pkg::STORE_LSB]
                       == mrie_pkg::OP_STORE_ACC_HI;
    // bits 9:8 left out on purpose, so any filler there still decodes
    wire logic is_lit  = lit_form(I_INSTR, mrie_pkg::OP_LOAD_LIT_HI);
    wire logic is_retl = lit_form(I_INSTR, mrie_pkg::OP_RET_LIT_HI);
    wire logic dest_f  = I_INSTR[mrie_pkg::DEST_BIT];
    wire logic [6:0] faddr = I_INSTR[mrie_pkg::FADDR_MSB:0];
    wire logic [7:0] lit   = I_INSTR[mrie_pkg::LIT_MSB:0];
    wire logic is_pop  = is_ret || is_rirq || is_retl;

    logic [7:0]  acc_q;
    logic        zero_q;
    logic [7:0]  irq_q;
    logic [12:0] pc_q;
    logic        we_q;
    logic [6:0]  waddr_q;
    logic [7:0]  wdata_q;
    logic        pop_q;
    logic        disc_q;
    logic        busy_q;

    // ==========================================================
    // sequencing: returns take a second, discarded slot
    always_comb begin
        state_d = state_q;
        case (state_q)
            MRIE_RUN:  if (take && is_pop) state_d = MRIE_SLOT;
            MRIE_SLOT: state_d = MRIE_RUN;
            default:   state_d = MRIE_RUN;
        endcase
    end

    always_ff @(posedge I_CLOCK) begin
        if (I_RST) begin
            state_q <= MRIE_RUN;
            pop_q   <= 1'b0;
            disc_q  <= 1'b0;
            busy_q  <= 1'b0;
            pc_q    <= mrie_pkg::PC_RST;
        end else begin
            state_q <= state_d;
            pop_q   <= take && is_pop;
            disc_q  <= take && is_pop;
            busy_q  <= take && is_pop;
            if (take && is_pop)
                pc_q <= I_STACK_TOP;
            else if (take)
                pc_q <= pc_q + mrie_pkg::PC_STEP;
        end
    end

    // ==========================================================
    // accumulator, zero flag, interrupt control
    always_ff @(posedge I_CLOCK) begin
        if (I_RST) begin
            acc_q  <= mrie_pkg::ZERO8;
            zero_q <= 1'b0;
            irq_q  <= mrie_pkg::IRQ_RST;
        end else if (take) begin
            if (is_move && !dest_f)
                acc_q <= I_FILE_RDATA;
            if (is_lit || is_retl)
                acc_q <= lit;
            if (is_move)
                zero_q <= I_FILE_RDATA == mrie_pkg::ZERO8;
            if (is_rirq)
                irq_q[mrie_pkg::IRQ_EN_BIT] <= 1'b1;
        end
    end

    // ==========================================================
    // file register write port
    always_ff @(posedge I_CLOCK) begin
        if (I_RST) begin
            we_q    <= 1'b0;
            waddr_q <= mrie_pkg::FADDR_RST;
            wdata_q <= mrie_pkg::ZERO8;
        end else begin
            we_q    <= take && (is_mvwf || (is_move && dest_f));
            waddr_q <= faddr;
            wdata_q <= is_mvwf ? acc_q : I_FILE_RDATA;
        end
    end

    assign O_FILE_WE       = we_q;
    assign O_FILE_ADDR     = waddr_q;
    assign O_FILE_WDATA    = wdata_q;
    assign O_ACC           = acc_q;
    assign O_ZERO          = zero_q;
    assign O_IRQ_CTRL      = irq_q;
    assign O_PC            = pc_q;
    assign O_STACK_POP     = pop_q;
    assign O_FETCH_DISCARD = disc_q;
    assign O_BUSY          = busy_q;

    // ==========================================================
    // checks
    chk_ret_slot: assert property (
        @(posedge I_CLOCK) disable iff (I_RST)
        take && is_pop |=> O_BUSY && O_FETCH_DISCARD ##1 !O_BUSY)
        else $error("return did not take two cycles");

    chk_ret_pc: assert property (
        @(posedge I_CLOCK) disable iff (I_RST)
        take && is_pop |=> O_PC == $past(I_STACK_TOP))
        else $error("pc not loaded from stack top");

    chk_irq_en_set: assert property (
        @(posedge I_CLOCK) disable iff (I_RST)
        take && is_rirq |=> O_IRQ_CTRL[mrie_pkg::IRQ_EN_BIT])
        else $error("interrupt enable not set");

    chk_zero_move: assert property (
        @(posedge I_CLOCK) disable iff (I_RST)
        take && is_move
            |=> O_ZERO == ($past(I_FILE_RDATA) == mrie_pkg::ZERO8))
        else $error("zero flag wrong after move");

    chk_flags_kept: assert property (
        @(posedge I_CLOCK) disable iff (I_RST)
        take && !is_move |=> $stable(O_ZERO))
        else $error("flag changed");

    chk_lit_load: assert property (
        @(posedge I_CLOCK) disable iff (I_RST)
        take && (is_lit || is_retl) |=> O_ACC == $past(lit))
        else $error("literal not loaded");

    chk_store_acc: assert property (
        @(posedge I_CLOCK) disable iff (I_RST)
        take && is_mvwf |=> O_FILE_WE && O_FILE_WDATA == $past(acc_q))
        else $error("store of accumulator wrong");

    chk_nop_step: assert property (
        @(posedge I_CLOCK) disable iff (I_RST)
        take && is_nop
            |=> O_PC == $past(pc_q) + mrie_pkg::PC_STEP && $stable(O_ACC))
        else $error("no-op changed state");

    chk_ret_acc: assert property (
        @(posedge I_CLOCK) disable iff (I_RST)
        take && is_ret |=> $stable(O_ACC))
        else $error("return changed accumulator");

    chk_move_acc: assert property (
        @(posedge I_CLOCK) disable iff (I_RST)
        take && is_move && !dest_f |=> O_ACC == $past(I_FILE_RDATA))
        else $error("move did not load accumulator");

    chk_slot_hold: assert property (
        @(posedge I_CLOCK) disable iff (I_RST)
        O_BUSY |=> $stable(O_PC) && $stable(O_ACC))
        else $error("state moved during discarded slot");

    // ==========================================================
    // covers
    cov_irq_return: cover property (@(posedge I_CLOCK) take && is_rirq);
    cov_lit_return: cover property (@(posedge I_CLOCK) take && is_retl);
    cov_zero_test:  cover property (@(posedge I_CLOCK)
        take && is_move && dest_f && I_FILE_RDATA == mrie_pkg::ZERO8);
    cov_busy_drop:  cover property (@(posedge I_CLOCK) O_BUSY && I_VALID);
endmodule
`default_nettype wire

// File: src/mrie_pkg.sv
// constants for the move and return instruction executor
`default_nettype none
package mrie_pkg;
    // ==========================================================
    // widths
    localparam int DATA_W  = 8;
    localparam int FADDR_W = 7;
    localparam int PC_W    = 13;
    localparam int INSTR_W = 14;
    // ==========================================================
    // opcode patterns (14-bit words)
    localparam logic [13:0] OP_NOP      = 14'h0000;
    localparam logic [13:0] OP_RETURN   = 14'h0008;
    localparam logic [13:0] OP_RETIRQ   = 14'h0009;
    localparam logic [5:0]  OP_MOVE_FILE_HI = 6'h08;
    localparam logic [6:0]  OP_STORE_ACC_HI = 7'h01;
    // literal forms: bits 9:8 are don't-care
    localparam logic [3:0]  OP_LOAD_LIT_HI  = 4'hc;
    localparam logic [3:0]  OP_RET_LIT_HI   = 4'hd;
    // ==========================================================
    // field positions
    localparam int DEST_BIT   = 7;
    localparam int IRQ_EN_BIT = 7;
    localparam int OPC_MSB    = 13;
    localparam int MOVE_LSB   = 8;
    localparam int STORE_LSB  = 7;
    localparam int LIT_OP_LSB = 10;
    localparam int FADDR_MSB  = 6;
    localparam int LIT_MSB    = 7;
    localparam logic [6:0]      FADDR_RST = 7'h00;
    localparam logic [PC_W-1:0] PC_STEP = 13'h0001;
    localparam logic [PC_W-1:0] PC_RST  = 13'h0000;
    localparam logic [7:0]      ZERO8   = 8'h00;
    localparam logic [7:0]      IRQ_RST = 8'h00;
endpackage
`default_nettype wire

// File: verif/mrie_exec_bench.sv
// self-checking bench for the move and return executor
`default_nettype none
module mrie_exec_bench;
    timeunit 1ns;
    timeprecision 1ps;
    // ==========================================================
    // stimulus and observed signals
    logic        clk  = 1'b0;
    logic        rst  = 1'b1;
    logic        vld  = 1'b0;
    logic [13:0] ins  = 14'h0000;
    logic [7:0]  rdat = 8'h00;
    logic [12:0] top  = 13'h0000;
    logic        we, zf, pop, dis, busy;
    logic [6:0]  wa;
    logic [7:0]  wd, acc, irq;
    logic [12:0] pc;
    int          n_errors  = 0;
    int          cmp_count = 0;
    mrie_exec DUT (.I_CLOCK(clk), .I_RST(rst), .I_VALID(vld),
        .I_INSTR(ins), .I_FILE_RDATA(rdat), .I_STACK_TOP(top),
        .O_FILE_WE(we), .O_FILE_ADDR(wa), .O_FILE_WDATA(wd), .O_ACC(acc),
        .O_ZERO(zf), .O_IRQ_CTRL(irq), .O_PC(pc), .O_STACK_POP(pop),
        .O_FETCH_DISCARD(dis), .O_BUSY(busy));
    initial begin
        forever #12.5 clk = ~clk;
    end
    // ==========================================================
    // shared tasks
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        cmp_count++;
        if (got !== exp) begin
            n_errors++;
            $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // one instruction offered for one edge, results read a cycle later
    task automatic run(input logic [13:0] w, input logic [7:0] rd);
        @(negedge clk);
        ins = w;
        rdat = rd;
        vld = 1'b1;
        @(negedge clk);
        vld = 1'b0;
    endtask
    task automatic print_verdict;
        $display("errors=%0d compares=%0d", n_errors, cmp_count);
        if (n_errors == 0 && cmp_count > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    // ==========================================================
    // scenarios
    task automatic t_lit;
        run(14'h30a5, 8'h00);
        chk(16'(acc), 16'h00a5);
        chk(16'(pc), 16'h0001);
        run(14'h335a, 8'h00);
        chk(16'(acc), 16'h005a);
        chk(16'(zf), 16'h0000);
    endtask
    task automatic t_move_file_reg;
        run(14'h0805, 8'h3c);
        chk(16'({acc, zf, we}), 16'h00f0);
        run(14'h08ff, 8'h00);
        chk(16'({we, wa, wd}), 16'hff00);
        chk(16'({acc, zf}), 16'h0079);
    endtask
    task automatic t_store_acc_to_file;
        run(14'h0080, 8'hff);
        chk(16'({we, wa, wd}), 16'h803c);
        chk(16'(zf), 16'h0001);
        run(14'h0000, 8'h00);
        chk(16'({we, acc, zf}), 16'h0079);
        chk(16'(pc), 16'h0006);
    endtask
    // a return, then a literal offered while busy must be ignored
    task automatic t_ret(input logic [13:0] w, input logic [12:0] tp,
                         input logic [7:0] eacc, input logic [7:0] eirq);
        top = tp;
        @(negedge clk);
        ins = w;
        vld = 1'b1;
        @(negedge clk);
        // valid stays high so the slot edge sees an offered literal
        ins = 14'h3011;
        chk(16'({pop, dis, busy}), 16'h0007);
        chk(16'(pc), 16'(tp));
        chk(16'({acc, irq}), {eacc, eirq});
        chk(16'(zf), 16'h0001);
        @(negedge clk);
        vld = 1'b0;
        chk(16'({pop, dis, busy}), 16'h0000);
        chk(16'(acc), 16'(eacc));
        chk(16'(pc), 16'(tp));
    endtask
    initial begin
        repeat (20) @(posedge clk);
        @(negedge clk);
        rst = 1'b0;
        chk(16'({acc, zf, pc[6:0]}), 16'h0000);
        t_lit();
        t_move_file_reg();
        t_store_acc_to_file();
        t_ret(14'h3477, 13'h1abc, 8'h77, 8'h00);
        t_ret(14'h0008, 13'h0456, 8'h77, 8'h00);
        t_ret(14'h0009, 13'h0123, 8'h77, 8'h80);
        print_verdict();
    end
endmodule
`default_nettype wire
